// File: shared/vplt_pkg.sv
// Package of constants and types for the virtual PHY loopback and turbo control block.
package vplt_pkg;

  // Register byte offsets on the register map and the serial management index.
  localparam logic [8:0] VPLT_P1_OFFSET = 9'h0DC;
  localparam logic [8:0] VPLT_P0_OFFSET = 9'h1DC;
  localparam logic [4:0] VPLT_MGMT_INDEX = 5'h1F;

  // Field positions inside the special control/status word.
  localparam int VPLT_MODE2_BIT    = 15;
  localparam int VPLT_LOOPBACK_BIT = 14;
  localparam int VPLT_TURBO_BIT    = 10;
  localparam int VPLT_MODE_LO_BIT  = 8;

  // Reset values of the writable fields.
  localparam logic VPLT_LOOPBACK_RESET = 1'b0;
  localparam logic VPLT_TURBO_RESET    = 1'b0;

  // Cycles the strap synchroniser needs before its output is valid.
  localparam logic [1:0] VPLT_STRAP_SETTLE = 2'h2;

  // Three-bit port mode encodings.
  localparam logic [2:0] VPLT_MODE_MII_MAC  = 3'h0;
  localparam logic [2:0] VPLT_MODE_MII_PHY  = 3'h1;
  localparam logic [2:0] VPLT_MODE_RMII_MAC = 3'h2;
  localparam logic [2:0] VPLT_MODE_RMII_PHY = 3'h3;
  localparam logic [2:0] VPLT_MODE_INT_PHY  = 3'h4;

  // Data rate the port runs at.
  typedef enum logic [1:0] {
    VPLT_RATE_10  = 2'h0,
    VPLT_RATE_100 = 2'h1,
    VPLT_RATE_200 = 2'h2
  } vplt_rate_t;

  // One nibble-wide media independent transfer.
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } vplt_mii_t;

  // Writable control fields of one port.
  typedef struct packed {
    logic loopback;
    logic turbo;
  } vplt_ctrl_t;

  localparam vplt_mii_t VPLT_MII_IDLE = 6'h00;

endpackage : vplt_pkg

// File: hdl/vplt_port.sv
// Per-port loopback steering and data rate selection.
`timescale 1ns/1ps
`default_nettype none

module vplt_port
(
  // Clock and reset.
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  // Control and mode.
  input  wire vplt_pkg::vplt_ctrl_t ctrl_in,
  input  wire logic [2:0]           mode_in,
  input  wire logic                 isolate_in,
  input  wire logic                 speed_100_in,
  input  wire logic                 ext_fast_in,
  // Data paths.
  input  wire vplt_pkg::vplt_mii_t  fab_tx_in,
  input  wire vplt_pkg::vplt_mii_t  ext_rx_in,
  output var  vplt_pkg::vplt_mii_t  ext_tx_out,
  output var  vplt_pkg::vplt_mii_t  fab_rx_out,
  output var  vplt_pkg::vplt_rate_t rate_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Steering. Isolation only cuts the external side, so the loop still works.
  wire logic                 is_mac;
  wire logic                 is_mii_phy;
  wire vplt_pkg::vplt_mii_t  ext_tx_d;
  wire vplt_pkg::vplt_mii_t  fab_rx_d;
  wire vplt_pkg::vplt_rate_t base_rate;
  wire vplt_pkg::vplt_rate_t rate_d;

  assign ext_tx_d = (ctrl_in.loopback || isolate_in) ? vplt_pkg::VPLT_MII_IDLE
                                                     : fab_tx_in;
  assign fab_rx_d = ctrl_in.loopback ? fab_tx_in
                  : (isolate_in ? vplt_pkg::VPLT_MII_IDLE : ext_rx_in);

  ////////////////////////////////////////////////////////////////////////////
  // Rate. MAC modes follow the attached PHY; turbo only lifts MII PHY mode.
  assign is_mac     = (mode_in == vplt_pkg::VPLT_MODE_MII_MAC) ||
                      (mode_in == vplt_pkg::VPLT_MODE_RMII_MAC);
  assign is_mii_phy = (mode_in == vplt_pkg::VPLT_MODE_MII_PHY);
  assign base_rate  = (is_mac ? ext_fast_in : speed_100_in) ? vplt_pkg::VPLT_RATE_100
                                                            : vplt_pkg::VPLT_RATE_10;
  assign rate_d     = (is_mii_phy && ctrl_in.turbo && base_rate == vplt_pkg::VPLT_RATE_100)
                      ? vplt_pkg::VPLT_RATE_200 : base_rate;

  // Outputs are registered so the fabric sees clean flop-driven signals.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ext_tx_out <= vplt_pkg::VPLT_MII_IDLE;
      fab_rx_out <= vplt_pkg::VPLT_MII_IDLE;
      rate_out   <= vplt_pkg::VPLT_RATE_10;
    end
    else
    begin
      ext_tx_out <= ext_tx_d;
      fab_rx_out <= fab_rx_d;
      rate_out   <= rate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the steering and rate choice.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_loop_no_ext;
    ctrl_in.loopback |=> (ext_tx_out == vplt_pkg::VPLT_MII_IDLE);
  endproperty
  a_loop_no_ext: assert property (p_loop_no_ext)
    else $error("Loopback frame leaked to external port.");

  property p_loop_iso;
    (ctrl_in.loopback && isolate_in && fab_tx_in.en) ##1 ctrl_in.loopback
      |-> fab_rx_out.en && (fab_rx_out.d == $past(fab_tx_in.d));
  endproperty
  a_loop_iso: assert property (p_loop_iso)
    else $error("Loopback stopped under isolation.");

  property p_turbo200;
    (is_mii_phy && ctrl_in.turbo && speed_100_in) |=> (rate_out == vplt_pkg::VPLT_RATE_200);
  endproperty
  a_turbo200: assert property (p_turbo200)
    else $error("Turbo did not select 200 Mbps.");

  property p_no200;
    !is_mii_phy |=> (rate_out != vplt_pkg::VPLT_RATE_200);
  endproperty
  a_no200: assert property (p_no200)
    else $error("200 Mbps outside MII PHY mode.");

  property p_rmii_rate;
    (mode_in == vplt_pkg::VPLT_MODE_RMII_PHY) |=>
      (rate_out == ($past(speed_100_in) ? vplt_pkg::VPLT_RATE_100 : vplt_pkg::VPLT_RATE_10));
  endproperty
  a_rmii_rate: assert property (p_rmii_rate)
    else $error("RMII PHY rate wrong.");

  property p_mac_follow;
    is_mac |=> (rate_out == ($past(ext_fast_in) ? vplt_pkg::VPLT_RATE_100
                                                : vplt_pkg::VPLT_RATE_10));
  endproperty
  a_mac_follow: assert property (p_mac_follow)
    else $error("MAC mode rate does not follow external PHY.");

endmodule : vplt_port

`default_nettype wire

// File: hdl/vplt_top.sv
// Virtual PHY special control/status logic for the two external switch ports.
//
// Overview of operation
// - Loopback set: fabric transmit frames skip external port, return as fabric receive.
// - Loopback keeps working while the virtual PHY isolate bit is set.
// - Turbo set: speed selection picks 10 or 200 instead of 10 or 100.
// - Turbo changes the rate only in MII PHY mode, nowhere else.
// - RMII stays at 100 or 10; MAC modes follow the external PHY.
// - Read-only mode bit 15 joins bits 9:8 into the three-bit port mode.
`timescale 1ns/1ps
`default_nettype none

module vplt_top
#(
  parameter logic TURBO_RESET = vplt_pkg::VPLT_TURBO_RESET
)
(
  // Clock and reset.
  input  wire logic                       mclk_in,
  input  wire logic                       reset_in,
  // Register map access.
  input  wire logic [8:0]                 reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [31:0]                reg_wdata_in,
  output var  logic [31:0]                reg_rdata_out,
  output var  logic                       reg_rvalid_out,
  // Serial management access.
  input  wire logic                       mgmt_port_in,
  input  wire logic [4:0]                 mgmt_index_in,
  input  wire logic                       mgmt_wr_in,
  input  wire logic                       mgmt_rd_in,
  input  wire logic [15:0]                mgmt_wdata_in,
  output var  logic [15:0]                mgmt_rdata_out,
  output var  logic                       mgmt_rvalid_out,
  // Mode straps, sampled from pins.
  input  wire logic [1:0]                 p0_mode_strap_in,
  input  wire logic [2:0]                 p1_mode_strap_in,
  // Per-port status from the virtual PHY, index 0 is port 0.
  input  wire logic [1:0]                 isolate_in,
  input  wire logic [1:0]                 speed_100_in,
  input  wire logic [1:0]                 ext_fast_in,
  // Per-port data paths.
  input  wire vplt_pkg::vplt_mii_t [1:0]  fab_tx_in,
  input  wire vplt_pkg::vplt_mii_t [1:0]  ext_rx_in,
  output var  vplt_pkg::vplt_mii_t [1:0]  ext_tx_out,
  output var  vplt_pkg::vplt_mii_t [1:0]  fab_rx_out,
  output var  vplt_pkg::vplt_rate_t [1:0] rate_out,
  output var  logic [2:0]                 p0_mode_out,
  output var  logic [2:0]                 p1_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser. Straps come from pins, so two flops precede any use.
  logic [4:0] strap_meta_q;
  logic [4:0] strap_sync_q;
  logic [1:0] strap_cnt_q;
  logic       strap_done_q;
  logic [2:0] mode_q [2];

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      strap_meta_q <= 5'h00;
      strap_sync_q <= 5'h00;
    end
    else
    begin
      strap_meta_q <= {p1_mode_strap_in, p0_mode_strap_in};
      strap_sync_q <= strap_meta_q;
    end
  end

  // Mode is caught once the synchroniser has filled after reset release.
  // Port 0 has no internal PHY, so its top mode bit is forced low.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      mode_q[0]    <= vplt_pkg::VPLT_MODE_MII_MAC;
      mode_q[1]    <= vplt_pkg::VPLT_MODE_MII_MAC;
    end
    else if (!strap_done_q)
    begin
      if (strap_cnt_q == vplt_pkg::VPLT_STRAP_SETTLE)
      begin
        strap_done_q <= 1'b1;
        mode_q[0]    <= {1'b0, strap_sync_q[1:0]};
        mode_q[1]    <= strap_sync_q[4:2];
      end
      else
      begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode. The register map wins over management when both write at once.
  wire logic [1:0]  reg_sel;
  wire logic        mgmt_hit;
  wire logic [1:0]  wr_hit;
  wire logic [15:0] wdata16;
  wire logic [15:0] status_word [2];

  assign reg_sel[0] = (reg_addr_in == vplt_pkg::VPLT_P0_OFFSET);
  assign reg_sel[1] = (reg_addr_in == vplt_pkg::VPLT_P1_OFFSET);
  assign mgmt_hit   = (mgmt_index_in == vplt_pkg::VPLT_MGMT_INDEX);
  assign wdata16    = reg_wr_in ? reg_wdata_in[15:0] : mgmt_wdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and the two port engines.
  vplt_pkg::vplt_ctrl_t ctrl_q [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_port
      assign wr_hit[gi] = (reg_wr_in && reg_sel[gi]) ||
                          (!reg_wr_in && mgmt_wr_in && mgmt_hit &&
                           (mgmt_port_in == 1'(gi)));

      // Only loopback and turbo are writable; the mode bits ignore writes.
      assign status_word[gi] = {mode_q[gi][2], ctrl_q[gi].loopback, 3'h0,
                                ctrl_q[gi].turbo, mode_q[gi][1:0], 8'h00};

      always_ff @(posedge mclk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          ctrl_q[gi].loopback <= vplt_pkg::VPLT_LOOPBACK_RESET;
          ctrl_q[gi].turbo    <= TURBO_RESET;
        end
        else if (wr_hit[gi])
        begin
          ctrl_q[gi].loopback <= wdata16[vplt_pkg::VPLT_LOOPBACK_BIT];
          ctrl_q[gi].turbo    <= wdata16[vplt_pkg::VPLT_TURBO_BIT];
        end
      end

      vplt_port u_port
      (
        .mclk_in      (mclk_in),
        .reset_in     (reset_in),
        .ctrl_in      (ctrl_q[gi]),
        .mode_in      (mode_q[gi]),
        .isolate_in   (isolate_in[gi]),
        .speed_100_in (speed_100_in[gi]),
        .ext_fast_in  (ext_fast_in[gi]),
        .fab_tx_in    (fab_tx_in[gi]),
        .ext_rx_in    (ext_rx_in[gi]),
        .ext_tx_out   (ext_tx_out[gi]),
        .fab_rx_out   (fab_rx_out[gi]),
        .rate_out     (rate_out[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read answers, one cycle after the request. Unmapped addresses read zero.
  wire logic [31:0] reg_rdata_d;
  wire logic [15:0] mgmt_rdata_d;

  assign reg_rdata_d  = reg_sel[0] ? {16'h0000, status_word[0]}
                      : (reg_sel[1] ? {16'h0000, status_word[1]} : 32'h0000_0000);
  assign mgmt_rdata_d = !mgmt_hit ? 16'h0000
                      : (mgmt_port_in ? status_word[1] : status_word[0]);

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out   <= 32'h0000_0000;
      reg_rvalid_out  <= 1'b0;
      mgmt_rdata_out  <= 16'h0000;
      mgmt_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out  <= reg_rd_in;
      mgmt_rvalid_out <= mgmt_rd_in;
      if (reg_rd_in)
      begin
        reg_rdata_out <= reg_rdata_d;
      end
      if (mgmt_rd_in)
      begin
        mgmt_rdata_out <= mgmt_rdata_d;
      end
    end
  end

  // Mode is also shown on pins so the port muxing can follow it.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      p0_mode_out <= vplt_pkg::VPLT_MODE_MII_MAC;
      p1_mode_out <= vplt_pkg::VPLT_MODE_MII_MAC;
    end
    else
    begin
      p0_mode_out <= mode_q[0];
      p1_mode_out <= mode_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register view of the mode and the control write path.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_mode_read;
    (reg_rd_in && reg_sel[1]) |=>
      (reg_rdata_out[15] == $past(mode_q[1][2])) &&
      (reg_rdata_out[9:8] == $past(mode_q[1][1:0]));
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("Port 1 mode bits misread.");

  property p_mode_hold;
    strap_done_q |=> $stable(mode_q[0]) && $stable(mode_q[1]) && (mode_q[0][2] == 1'b0);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("Port mode changed after capture.");

  property p_loop_write;
    (reg_wr_in && reg_sel[0]) |=>
      (ctrl_q[0].loopback == $past(reg_wdata_in[vplt_pkg::VPLT_LOOPBACK_BIT]))
      ##1 (ext_tx_out[0].en == 1'b0) || !ctrl_q[0].loopback || !$past(ctrl_q[0].loopback);
  endproperty
  a_loop_write: assert property (p_loop_write)
    else $error("Loopback write not applied.");

endmodule : vplt_top

`default_nettype wire

// File: testbench/vplt_far_end.sv
// Far-end model of the external MAC or PHY on both ports.
`timescale 1ns/1ps
`default_nettype none

module vplt_far_end
(
  // Clock and reset.
  input  wire logic                      mclk_in,
  input  wire logic                      reset_in,
  // Link side.
  input  wire logic                      send_in,
  input  wire vplt_pkg::vplt_mii_t [1:0] ext_tx_in,
  output var  vplt_pkg::vplt_mii_t [1:0] ext_rx_out,
  output var  logic [15:0]               seen_out
);
  logic [3:0] cnt_q = 4'h0;

  initial ext_rx_out = '0;

  // Frames carry a counting nibble; between frames the data toggles so a stale value never passes.
  always @(negedge mclk_in)
  begin
    cnt_q <= cnt_q + 4'h1;
    ext_rx_out[0] <= {send_in, 1'b0, send_in ? cnt_q : ~cnt_q};
    ext_rx_out[1] <= {send_in, 1'b0, send_in ? ~cnt_q : cnt_q};
  end

  // Counts cycles in which the device puts a nibble on either external transmit path.
  always @(posedge mclk_in or posedge reset_in)
    if (reset_in)
      seen_out <= 16'h0000;
    else
      seen_out <= seen_out + {15'h0000, ext_tx_in[0].en | ext_tx_in[1].en};
endmodule : vplt_far_end
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the loopback and turbo control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                       mclk_in = 1'b0;
  logic                       reset_in = 1'b1;
  logic [8:0]                 ra = 9'h000;
  logic                       rw = 1'b0;
  logic                       rr = 1'b0;
  logic [31:0]                rwd = 32'h00000000;
  logic [31:0]                rrd;
  logic                       rrv;
  logic                       mp = 1'b0;
  logic [4:0]                 mi = 5'h00;
  logic                       mw = 1'b0;
  logic                       mr = 1'b0;
  logic [15:0]                mwd = 16'h0000;
  logic [15:0]                mrd;
  logic                       mrv;
  logic [1:0]                 p0s = 2'h0;
  logic [2:0]                 p1s = 3'h0;
  logic [1:0]                 iso = 2'h0;
  logic [1:0]                 spd = 2'h0;
  logic [1:0]                 xf = 2'h0;
  logic                       send = 1'b0;
  logic [15:0]                seen;
  logic [15:0]                s0;
  logic [2:0]                 m0;
  logic [2:0]                 m1;
  logic [2:0]                 p0m;
  logic [2:0]                 p1m;
  vplt_pkg::vplt_mii_t [1:0]  ftx = '0;
  vplt_pkg::vplt_mii_t [1:0]  erx;
  vplt_pkg::vplt_mii_t [1:0]  e;
  vplt_pkg::vplt_mii_t [1:0]  etx;
  vplt_pkg::vplt_mii_t [1:0]  frx;
  vplt_pkg::vplt_rate_t [1:0] rate;
  int                         fails = 0;
  int                         samples_checked = 0;
  int                         cycles = 0;

  vplt_top u_vplt_top (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(ra),
    .reg_wr_in(rw), .reg_rd_in(rr), .reg_wdata_in(rwd), .reg_rdata_out(rrd),
    .reg_rvalid_out(rrv), .mgmt_port_in(mp), .mgmt_index_in(mi), .mgmt_wr_in(mw),
    .mgmt_rd_in(mr), .mgmt_wdata_in(mwd), .mgmt_rdata_out(mrd), .mgmt_rvalid_out(mrv),
    .p0_mode_strap_in(p0s), .p1_mode_strap_in(p1s), .isolate_in(iso), .speed_100_in(spd),
    .ext_fast_in(xf), .fab_tx_in(ftx), .ext_rx_in(erx), .ext_tx_out(etx),
    .fab_rx_out(frx), .rate_out(rate), .p0_mode_out(p0m), .p1_mode_out(p1m));

  vplt_far_end u_vplt_far_end (.mclk_in(mclk_in), .reset_in(reset_in), .send_in(send),
    .ext_tx_in(etx), .ext_rx_out(erx), .seen_out(seen));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a hang limit well above the few hundred cycles the tests need.
  always #25 mclk_in = ~mclk_in;

  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_mii(input vplt_pkg::vplt_mii_t got, input vplt_pkg::vplt_mii_t exp);
    cmp_word({26'h0, got}, {26'h0, exp});
  endtask : cmp_mii

  task automatic cmp_rate(input vplt_pkg::vplt_rate_t got, input vplt_pkg::vplt_rate_t exp);
    cmp_word({30'h0, got}, {30'h0, exp});
  endtask : cmp_rate

  // Expected low half of the status word.
  function automatic logic [15:0] ew(input logic [2:0] m, input logic lb, input logic t);
    return {m[2], lb, 3'h0, t, m[1:0], 8'h00};
  endfunction : ew

  // Expected rate: only MII PHY mode lets turbo lift the fast rate.
  function automatic vplt_pkg::vplt_rate_t er(input logic [2:0] m, input logic s,
                                              input logic t, input logic x);
    if (m == 3'h0 || m == 3'h2)
      return x ? vplt_pkg::VPLT_RATE_100 : vplt_pkg::VPLT_RATE_10;
    if (!s)
      return vplt_pkg::VPLT_RATE_10;
    return (m == 3'h1 && t) ? vplt_pkg::VPLT_RATE_200 : vplt_pkg::VPLT_RATE_100;
  endfunction : er

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks start and end just after a falling edge; strobes stand one cycle.
  task automatic reg_write(input logic [8:0] a, input logic [31:0] d);
    ra = a;
    rwd = d;
    rw = 1'b1;
    @(negedge mclk_in);
    rw = 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [8:0] a, input logic [31:0] x);
    ra = a;
    rr = 1'b1;
    @(negedge mclk_in);
    rr = 1'b0;
    cmp_word({31'h0, rrv}, 32'h1);
    cmp_word(rrd, x);
  endtask : reg_check

  task automatic mg_write(input logic p, input logic [15:0] d);
    mp = p;
    mi = vplt_pkg::VPLT_MGMT_INDEX;
    mwd = d;
    mw = 1'b1;
    @(negedge mclk_in);
    mw = 1'b0;
  endtask : mg_write

  task automatic mg_check(input logic p, input logic [4:0] i, input logic [15:0] x);
    mp = p;
    mi = i;
    mr = 1'b1;
    @(negedge mclk_in);
    mr = 1'b0;
    cmp_word({31'h0, mrv}, 32'h1);
    cmp_word({16'h0, mrd}, {16'h0, x});
  endtask : mg_check

  // Four nibbles per port; outputs follow one cycle later.
  task automatic data_check(input logic [1:0] lb);
    for (int i = 0; i < 4; i++)
    begin
      ftx = {{1'b1, 1'b1, 4'(i + 9)}, {1'b1, 1'b0, 4'(i + 3)}};
      @(posedge mclk_in);
      e = erx;
      @(negedge mclk_in);
      for (int p = 0; p < 2; p++)
      begin
        cmp_mii(frx[p], lb[p] ? ftx[p] : (iso[p] ? vplt_pkg::VPLT_MII_IDLE : e[p]));
        cmp_mii(etx[p], (lb[p] | iso[p]) ? vplt_pkg::VPLT_MII_IDLE : ftx[p]);
      end
    end
  endtask : data_check

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int k = 0; k < 5; k++)
    begin
      p1s = k[2:0];
      p0s = k[1:0];
      m1 = k[2:0];
      m0 = {1'b0, k[1:0]};
      reset_in = 1'b1;
      repeat (3) @(negedge mclk_in);
      reset_in = 1'b0;
      repeat (6) @(negedge mclk_in);
      cmp_word({29'h0, p0m}, {29'h0, m0});
      cmp_word({29'h0, p1m}, {29'h0, m1});
      reg_check(vplt_pkg::VPLT_P1_OFFSET, {16'h0, ew(m1, 1'b0, vplt_pkg::VPLT_TURBO_RESET)});
      mg_check(1'b0, 5'h1F, ew(m0, 1'b0, vplt_pkg::VPLT_TURBO_RESET));
      for (int j = 0; j < 8; j++)
      begin
        reg_write(vplt_pkg::VPLT_P0_OFFSET, {21'h0, j[2], 10'h000});
        mg_write(1'b1, {5'h00, j[2], 10'h000});
        spd = {2{j[0]}};
        xf = {2{j[1]}};
        repeat (2) @(negedge mclk_in);
        cmp_rate(rate[0], er(m0, j[0], j[2], j[1]));
        cmp_rate(rate[1], er(m1, j[0], j[2], j[1]));
      end
    end
    // Unmapped places read zero and take no write.
    reg_write(9'h0D8, 32'h0000FFFF);
    reg_check(9'h0D8, 32'h00000000);
    mg_check(1'b0, 5'h06, 16'h0000);
    send = 1'b1;
    data_check(2'b00);
    iso = 2'b01;
    data_check(2'b00);
    // Half-duplex receive-own-transmit setting lives outside this block.
    reg_write(vplt_pkg::VPLT_P0_OFFSET, 32'h00004000);
    mg_write(1'b1, 16'h4000);
    iso = 2'b11;
    // The last nibble sent before loopback took hold is still counted one edge later.
    @(negedge mclk_in);
    s0 = seen;
    data_check(2'b11);
    cmp_word({16'h0, seen}, {16'h0, s0});
    // A management write in the same cycle as a register write is dropped.
    ra = vplt_pkg::VPLT_P0_OFFSET;
    rwd = 32'h00004400;
    rw = 1'b1;
    mp = 1'b1;
    mi = vplt_pkg::VPLT_MGMT_INDEX;
    mwd = 16'h0400;
    mw = 1'b1;
    @(negedge mclk_in);
    rw = 1'b0;
    mw = 1'b0;
    reg_check(vplt_pkg::VPLT_P0_OFFSET, {16'h0, ew(3'h0, 1'b1, 1'b1)});
    mg_check(1'b1, 5'h1F, ew(3'h4, 1'b1, 1'b0));
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
